/* light_prox_pkg.sv */
package light_prox_pkg;

  // Sequencer timebase: one integration or wait step.
  localparam int unsigned MCLK_PERIOD_NS = 4;
  localparam int unsigned STEP_TIME_NS = 2720000;
  localparam int unsigned STEP_CYCLES = STEP_TIME_NS / MCLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W = 20;

  // Emitter burst timing on the link clock.
  localparam int unsigned LINK_PERIOD_NS = 12;
  localparam int unsigned PULSE_PERIOD_NS = 16000;
  localparam int unsigned PULSE_ON_NS = 7300;
  localparam int unsigned PULSE_PERIOD_CYCLES = PULSE_PERIOD_NS / LINK_PERIOD_NS;
  localparam int unsigned PULSE_ON_CYCLES = PULSE_ON_NS / LINK_PERIOD_NS;
  localparam int unsigned PHASE_W = 11;

  // Step count encoding and wait stretch.
  localparam logic [7:0] TIME_TERMINAL = 8'hFF;
  localparam int unsigned LONG_WAIT_FACTOR = 12;
  localparam logic [3:0] LONG_WAIT_LAST = 4'(LONG_WAIT_FACTOR - 1);
  localparam logic [3:0] SUB_ZERO = 4'h0;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // Enable register layout, register address zero.
  localparam logic [4:0] ENABLE_ADDR = 5'h00;
  localparam int unsigned POWER_ON_POS = 0;
  localparam int unsigned AMBIENT_EN_POS = 1;
  localparam int unsigned PROX_EN_POS = 2;
  localparam int unsigned WAIT_EN_POS = 3;

  typedef enum logic [1:0] {
    GAIN_X1 = 2'h0,
    GAIN_X8 = 2'h1,
    GAIN_X16 = 2'h2,
    GAIN_X120 = 2'h3
  } gain_t;

  typedef enum logic [1:0] {
    DRIVE_100MA = 2'h0,
    DRIVE_50MA = 2'h1,
    DRIVE_25MA = 2'h2,
    DRIVE_12MA5 = 2'h3
  } drive_t;

  typedef enum logic [1:0] {
    DIODE_NONE = 2'h0,
    DIODE_BROADBAND = 2'h1,
    DIODE_INFRARED = 2'h2,
    DIODE_BOTH = 2'h3
  } diode_t;

  typedef enum logic [2:0] {
    ST_SLEEP = 3'h0,
    ST_POWER_DELAY = 3'h1,
    ST_START = 3'h2,
    ST_PROX_ACCUM = 3'h3,
    ST_PROX_CONV = 3'h4,
    ST_WAIT = 3'h5,
    ST_LIGHT = 3'h6
  } seq_state_t;

  typedef struct packed {
    logic [7:0] enable_bits;
    logic long_wait_bit;
    logic [7:0] light_integration_time;
    logic [7:0] prox_integration_time;
    logic [7:0] wait_duration;
    logic [7:0] prox_pulse_count;
    drive_t emitter_current_select;
    diode_t prox_diode_select;
    gain_t light_gain_select;
  } seq_cfg_t;

  typedef struct packed {
    logic [15:0] broadband;
    logic [15:0] infrared;
  } light_pair_t;

endpackage : light_prox_pkg

/* sync3.sv */
module sync3 (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic d,
  output logic q
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // The first stage feeds only the second; a change counts once stages two and three agree.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end

endmodule : sync3

/* emitter_burst.sv */
module emitter_burst
  import light_prox_pkg::*;
#(
  parameter int unsigned period_cycles = PULSE_PERIOD_CYCLES,
  parameter int unsigned on_cycles = PULSE_ON_CYCLES
) (
  input wire logic link_clk,
  input wire logic rst_b,
  input wire logic burst_req_tgl,
  input wire logic [7:0] pulse_count,
  output logic sink_on_reg,
  output logic burst_done_tgl_reg
);

  logic req_sync;
  logic req_seen_reg;
  logic busy_reg;
  logic [7:0] remain_reg;
  logic [PHASE_W-1:0] phase_reg;
  logic start;
  logic period_end;

  // The request toggle crosses from the sequencer clock.
  sync3 u_req_sync (
    .clk(link_clk),
    .rst_b(rst_b),
    .d(burst_req_tgl),
    .q(req_sync)
  );

  assign start = req_sync != req_seen_reg;
  assign period_end = phase_reg == PHASE_W'(period_cycles - 1);

  // Edge memory for the synchronised request.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_seen_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_sync;
    end
  end

  // Burst counter; the pulse count is held steady by the sequencer during a burst.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      remain_reg <= COUNT_ZERO;
      phase_reg <= '0;
      burst_done_tgl_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= pulse_count != COUNT_ZERO; // R14
      remain_reg <= pulse_count; // R14
      phase_reg <= '0;
      if (pulse_count == COUNT_ZERO) begin
        burst_done_tgl_reg <= ~burst_done_tgl_reg;
      end
    end else if (busy_reg) begin
      if (period_end) begin
        phase_reg <= '0; // R15
        remain_reg <= remain_reg - COUNT_ONE;
        if (remain_reg == COUNT_ONE) begin
          busy_reg <= 1'b0;
          burst_done_tgl_reg <= ~burst_done_tgl_reg;
        end
      end else begin
        phase_reg <= phase_reg + PHASE_W'(1);
      end
    end
  end

  // Sink is on for the first part of each period and off for the rest.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sink_on_reg <= 1'b0;
    end else begin
      sink_on_reg <= busy_reg && !start && (phase_reg < PHASE_W'(on_cycles)); // R22
    end
  end

  sink_on_time_a: assert property (@(posedge link_clk) disable iff (!rst_b) // R22
    sink_on_reg |-> (busy_reg || $past(busy_reg)) && (phase_reg <= PHASE_W'(on_cycles)))
    else $error("Emitter sink on outside a burst.");

  pulse_period_a: assert property (@(posedge link_clk) disable iff (!rst_b) // R15
    (busy_reg && !start && !period_end) |=> phase_reg == $past(phase_reg) + PHASE_W'(1))
    else $error("Emitter phase counter skipped.");

endmodule : emitter_burst

/* light_prox_sequencer.sv */
// Behaviour
// R01: After reset, sleep with no measurements.
// R02: Power-on bit leaves sleep toward start.
// R03: Power-on bit is bit zero, address zero.
// R04: Start, proximity, wait, light, each if enabled.
// R05: Power-off finishes running conversions, then sleeps.
// R06: Both light channels integrate, then results transfer.
// R07: Channel results double-buffered against partial reads.
// R08: Duration is 2.72 ms times 256 minus value.
// R09: Host prefers 0xED light time for ripple.
// R10: Two-bit gain code selects 1, 8, 16, 120.
// R11: Diode select routes infrared, broadband or both.
// R12: Proximity conversion end latches proximity result.
// R13: Current select sets emitter sink drive level.
// R14: Burst emits programmed count of 1 to 255.
// R15: Emitter pulses spaced sixteen microseconds apart.
// R16: Host keeps proximity time at least 0xFF.
// R17: One step delay after power-on before start.
// R18: Proximity runs accumulate then conversion when enabled.
// R19: Wait state when enabled; long wait twelve times.
// R20: Light state ends at terminal, latches, flags status.
// R21: Timed states count steps from value to 0xFF.
// R22: Sink on fixed time, off rest of period.
module light_prox_sequencer
  import light_prox_pkg::*;
#(
  parameter int unsigned step_cycles = STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire seq_cfg_t cfg,
  input wire light_pair_t light_adc,
  input wire logic [15:0] prox_adc,
  input wire logic read_hold,
  input wire logic light_valid_clear,
  input wire logic prox_valid_clear,
  output seq_state_t state_reg,
  output logic [15:0] broadband_channel_count,
  output logic [15:0] infrared_channel_count,
  output logic [15:0] prox_result,
  output logic light_valid_reg,
  output logic prox_valid_reg,
  output logic light_integrating_reg,
  output gain_t light_gain_reg,
  output diode_t diode_route_reg,
  output drive_t emitter_drive_reg,
  output logic emitter_sink_pin
);

  seq_state_t state_next;
  logic power_on;
  logic prox_en;
  logic wait_en;
  logic ambient_en;
  logic [STEP_CNT_W-1:0] step_cnt_reg;
  logic step_tick;
  logic [7:0] step_pos_reg;
  logic [7:0] step_load;
  logic [3:0] wait_sub_reg;
  logic timed_state;
  logic timed_done;
  logic state_change;
  logic burst_req_tgl_reg;
  logic [7:0] pulse_count_reg;
  logic burst_done_tgl;
  logic done_sync;
  logic done_seen_reg;
  logic burst_done;
  light_pair_t shadow_reg;
  logic shadow_pending_reg;
  logic publish;
  logic light_end;
  logic prox_end;

  // Enable bits sit in the register at address zero.
  assign power_on = cfg.enable_bits[POWER_ON_POS]; // R03
  assign ambient_en = cfg.enable_bits[AMBIENT_EN_POS];
  assign prox_en = cfg.enable_bits[PROX_EN_POS];
  assign wait_en = cfg.enable_bits[WAIT_EN_POS];

  // States that run on the step timebase.
  assign timed_state = (state_reg == ST_POWER_DELAY) || (state_reg == ST_PROX_CONV) ||
                       (state_reg == ST_WAIT) || (state_reg == ST_LIGHT);
  assign state_change = state_next != state_reg;
  assign step_tick = timed_state && (step_cnt_reg == STEP_CNT_W'(step_cycles - 1));

  // A timed state ends on the step tick taken at the terminal value; long wait
  // needs twelve sub-steps per step before the position may move.
  assign timed_done = step_tick && (step_pos_reg == TIME_TERMINAL) && // R21
                      ((state_reg != ST_WAIT) || !cfg.long_wait_bit ||
                       (wait_sub_reg == LONG_WAIT_LAST)); // R19
  assign light_end = (state_reg == ST_LIGHT) && timed_done;
  assign prox_end = (state_reg == ST_PROX_CONV) && timed_done;

  // Next state. Power-off is honoured at once in power delay and start, elsewhere only at the end of
  // proximity conversion, wait and light so that a conversion in flight always completes before sleep.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: begin
        if (power_on) begin
          state_next = ST_POWER_DELAY; // R02
        end
      end
      ST_POWER_DELAY: begin
        if (!power_on) begin
          state_next = ST_SLEEP;
        end else if (timed_done) begin
          state_next = ST_START; // R17
        end
      end
      ST_START: begin
        if (!power_on) begin
          state_next = ST_SLEEP;
        end else if (prox_en) begin
          state_next = ST_PROX_ACCUM; // R04
        end else if (wait_en) begin
          state_next = ST_WAIT;
        end else if (ambient_en) begin
          state_next = ST_LIGHT;
        end
      end
      ST_PROX_ACCUM: begin
        if (burst_done) begin
          state_next = ST_PROX_CONV; // R18
        end
      end
      ST_PROX_CONV: begin
        if (prox_end) begin
          if (!power_on) begin
            state_next = ST_SLEEP; // R05
          end else if (wait_en) begin
            state_next = ST_WAIT; // R04
          end else if (ambient_en) begin
            state_next = ST_LIGHT;
          end else begin
            state_next = ST_START;
          end
        end
      end
      ST_WAIT: begin
        if (timed_done) begin
          if (!power_on) begin
            state_next = ST_SLEEP; // R05
          end else if (ambient_en) begin
            state_next = ST_LIGHT; // R04
          end else begin
            state_next = ST_START;
          end
        end
      end
      ST_LIGHT: begin
        if (light_end) begin
          state_next = power_on ? ST_START : ST_SLEEP; // R05
        end
      end
      default: begin
        state_next = ST_SLEEP;
      end
    endcase
  end

  // Sequencer state; reset parks it in sleep.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_SLEEP; // R01
    end else begin
      state_reg <= state_next;
    end
  end

  // Starting position of the step count for the state being entered.
  always_comb begin
    case (state_next)
      ST_PROX_CONV: step_load = cfg.prox_integration_time;
      ST_WAIT: step_load = cfg.wait_duration;
      ST_LIGHT: step_load = cfg.light_integration_time;
      default: step_load = TIME_TERMINAL;
    endcase
  end

  // Cycle prescaler for one step; restarts on every state change.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      step_cnt_reg <= '0;
    end else if (state_change || step_tick || !timed_state) begin
      step_cnt_reg <= '0;
    end else begin
      step_cnt_reg <= step_cnt_reg + STEP_CNT_W'(1);
    end
  end

  // Step position runs from the programmed value up to 0xFF, giving
  // 256 minus value steps in all.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      step_pos_reg <= TIME_TERMINAL;
      wait_sub_reg <= SUB_ZERO;
    end else if (state_change) begin
      step_pos_reg <= step_load; // R08
      wait_sub_reg <= SUB_ZERO;
    end else if (step_tick) begin
      if ((state_reg == ST_WAIT) && cfg.long_wait_bit && (wait_sub_reg != LONG_WAIT_LAST)) begin
        wait_sub_reg <= wait_sub_reg + 4'h1; // R19
      end else begin
        wait_sub_reg <= SUB_ZERO;
        step_pos_reg <= step_pos_reg + 8'h01; // R21
      end
    end
  end

  // Burst request and emitter settings; held steady until the burst returns.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      burst_req_tgl_reg <= 1'b0;
      pulse_count_reg <= COUNT_ZERO;
      emitter_drive_reg <= DRIVE_100MA;
      diode_route_reg <= DIODE_NONE;
    end else if (state_change && (state_next == ST_PROX_ACCUM)) begin
      burst_req_tgl_reg <= ~burst_req_tgl_reg;
      pulse_count_reg <= cfg.prox_pulse_count; // R14
      emitter_drive_reg <= cfg.emitter_current_select; // R13
      diode_route_reg <= cfg.prox_diode_select; // R11
    end
  end

  // Emitter burst generator runs on the link clock.
  emitter_burst u_emitter (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .burst_req_tgl(burst_req_tgl_reg),
    .pulse_count(pulse_count_reg),
    .sink_on_reg(emitter_sink_pin),
    .burst_done_tgl_reg(burst_done_tgl)
  );

  // Completion toggle comes back across the domain boundary.
  sync3 u_done_sync (
    .clk(mclk),
    .rst_b(rst_b),
    .d(burst_done_tgl),
    .q(done_sync)
  );

  assign burst_done = done_sync != done_seen_reg;

  // Edge memory for the returned completion.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      done_seen_reg <= 1'b0;
    end else begin
      done_seen_reg <= done_sync;
    end
  end

  // Light front end integrates both channels together during the light state.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      light_integrating_reg <= 1'b0;
      light_gain_reg <= GAIN_X1;
    end else begin
      light_integrating_reg <= state_next == ST_LIGHT; // R06
      if (state_change && (state_next == ST_LIGHT)) begin
        light_gain_reg <= cfg.light_gain_select; // R10
      end
    end
  end

  // Shadow stage catches both channels at the end of integration.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shadow_reg <= '0;
    end else if (light_end) begin
      shadow_reg <= light_adc; // R06
    end
  end

  // The readable copy moves only while no read is under way, so a read
  // never sees one channel old and the other new.
  assign publish = shadow_pending_reg && !read_hold; // R07

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shadow_pending_reg <= 1'b0;
    end else if (light_end) begin
      shadow_pending_reg <= 1'b1;
    end else if (publish) begin
      shadow_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      broadband_channel_count <= '0;
      infrared_channel_count <= '0;
    end else if (publish) begin
      broadband_channel_count <= shadow_reg.broadband; // R07
      infrared_channel_count <= shadow_reg.infrared;
    end
  end

  // Proximity result latches at the end of its conversion.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prox_result <= '0;
    end else if (prox_end) begin
      prox_result <= prox_adc; // R12
    end
  end

  // Sticky status flags; a new result beats a clear in the same cycle.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      light_valid_reg <= 1'b0;
      prox_valid_reg <= 1'b0;
    end else begin
      if (publish) begin
        light_valid_reg <= 1'b1; // R20
      end else if (light_valid_clear) begin
        light_valid_reg <= 1'b0;
      end
      if (prox_end) begin
        prox_valid_reg <= 1'b1;
      end else if (prox_valid_clear) begin
        prox_valid_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sleep_hold_a: assert property ( // R01
    (state_reg == ST_SLEEP && !power_on) |=> state_reg == ST_SLEEP)
    else $error("Sequencer left sleep without power-on.");

  power_wake_a: assert property ( // R02
    (state_reg == ST_SLEEP && power_on) |=> state_reg == ST_POWER_DELAY)
    else $error("Power-on did not leave sleep.");

  power_delay_a: assert property ( // R17
    (state_reg == ST_POWER_DELAY && state_next == ST_START) |-> step_tick)
    else $error("Start entered before the power-up step.");

  wait_order_a: assert property ( // R04
    (state_reg == ST_WAIT) |=> state_reg inside {ST_WAIT, ST_LIGHT, ST_START, ST_SLEEP})
    else $error("Wait state left in wrong order.");

  light_finish_a: assert property ( // R05
    (state_reg == ST_LIGHT && !light_end) |=> state_reg == ST_LIGHT)
    else $error("Light conversion cut short.");

  shadow_capture_a: assert property ( // R06
    light_end |=> shadow_reg == $past(light_adc) && shadow_pending_reg)
    else $error("Light channels not captured together.");

  read_stable_a: assert property ( // R07
    read_hold |=> $stable(broadband_channel_count) && $stable(infrared_channel_count))
    else $error("Channel counts changed during a read.");

  prox_latch_a: assert property ( // R12
    prox_end |=> prox_result == $past(prox_adc) && prox_valid_reg)
    else $error("Proximity result not latched.");

  terminal_count_a: assert property ( // R21
    (timed_state && state_change && state_reg != ST_POWER_DELAY) |->
      step_pos_reg == TIME_TERMINAL || !power_on)
    else $error("Timed state left before terminal count.");

  long_wait_a: assert property ( // R19
    (state_reg == ST_WAIT && timed_done && cfg.long_wait_bit) |-> wait_sub_reg == LONG_WAIT_LAST)
    else $error("Long wait ended early.");

  cover_power_up: cover property (state_reg == ST_POWER_DELAY ##1 state_reg == ST_START);
  cover_prox_burst: cover property (state_reg == ST_PROX_ACCUM ##1 state_reg == ST_PROX_CONV);
  cover_long_wait: cover property (state_reg == ST_WAIT && cfg.long_wait_bit && timed_done);
  cover_publish: cover property (light_end ##[1:20] publish);

endmodule : light_prox_sequencer

/* light_prox_far_end.sv */
module light_prox_far_end
  import light_prox_pkg::*;
(
  input wire logic link_clk,
  input wire logic rst_b,
  input wire logic emitter_sink_pin,
  input wire light_pair_t light_set,
  input wire logic [15:0] prox_set,
  output light_pair_t light_adc,
  output logic [15:0] prox_adc,
  output logic [15:0] pulse_cnt,
  output logic [15:0] on_len,
  output logic [15:0] period_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sink_d;
  logic [15:0] run_on;
  logic [15:0] run_per;

  // The converters present the scene level that the bench chose for this run.
  assign light_adc = light_set;
  assign prox_adc = prox_set;

  // Emitter watch: counts pulses, on-time and rise-to-rise period in link cycles.
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      sink_d <= 1'b0;
      run_on <= 16'h0000;
      run_per <= 16'h0000;
      pulse_cnt <= 16'h0000;
      on_len <= 16'h0000;
      period_len <= 16'h0000;
    end else begin
      sink_d <= emitter_sink_pin;
      run_on <= emitter_sink_pin ? run_on + 16'h0001 : 16'h0000;
      run_per <= run_per + 16'h0001;
      if (emitter_sink_pin && !sink_d) begin
        pulse_cnt <= pulse_cnt + 16'h0001;
        period_len <= run_per;
        run_per <= 16'h0001;
      end
      if (!emitter_sink_pin && sink_d) begin
        on_len <= run_on;
      end
    end
  end
endmodule : light_prox_far_end

/* light_proximity_measurement_sequencer_tb.sv */
module light_proximity_measurement_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import light_prox_pkg::*;
  localparam int unsigned STEP = 50;
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic read_hold = 1'b0;
  logic lv_clr = 1'b0;
  logic pv_clr = 1'b0;
  seq_cfg_t cfg = '0;
  light_pair_t light_set = '0;
  light_pair_t light_adc;
  logic [15:0] prox_set = 16'h0000;
  logic [15:0] prox_adc;
  logic [15:0] pulse_cnt;
  logic [15:0] on_len;
  logic [15:0] period_len;
  seq_state_t state_reg;
  logic [15:0] bb_cnt;
  logic [15:0] ir_cnt;
  logic [15:0] prox_result;
  logic light_valid_reg;
  logic prox_valid_reg;
  gain_t light_gain_reg;
  diode_t diode_route_reg;
  drive_t emitter_drive_reg;
  logic sink;
  int error_cnt = 0;
  int total_checks = 0;
  light_pair_t light_q[$];
  logic [15:0] prox_q[$];
  logic lv_d = 1'b0;
  logic pv_d = 1'b0;
  logic integ;
  // Per-round light time, wait time and pulse count.
  logic [7:0] lt [4] = '{8'hED, 8'hFF, 8'hFE, 8'hFD};
  logic [7:0] wt [4] = '{8'hFF, 8'hFE, 8'hFE, 8'hFF};
  logic [7:0] pc [4] = '{8'h02, 8'h01, 8'h03, 8'h01};

  initial begin
    forever #2 mclk = ~mclk;
  end
  // The link clock starts off phase so the two domains never line up.
  initial begin
    #1.7;
    forever #6 link_clk = ~link_clk;
  end

  light_prox_sequencer #(.step_cycles(STEP)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .link_clk(link_clk), .cfg(cfg), .light_adc(light_adc), .prox_adc(prox_adc),
    .read_hold(read_hold), .light_valid_clear(lv_clr), .prox_valid_clear(pv_clr),
    .state_reg(state_reg), .broadband_channel_count(bb_cnt), .infrared_channel_count(ir_cnt),
    .prox_result(prox_result), .light_valid_reg(light_valid_reg),
    .prox_valid_reg(prox_valid_reg), .light_integrating_reg(integ),
    .light_gain_reg(light_gain_reg),
    .diode_route_reg(diode_route_reg), .emitter_drive_reg(emitter_drive_reg),
    .emitter_sink_pin(sink));
  light_prox_far_end far_u (.link_clk(link_clk), .rst_b(rst_b), .emitter_sink_pin(sink),
    .light_set(light_set), .prox_set(prox_set), .light_adc(light_adc), .prox_adc(prox_adc),
    .pulse_cnt(pulse_cnt), .on_len(on_len), .period_len(period_len));

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string name, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("BAD %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_range

  // Bounded wait for a state; returns the cycles spent getting there.
  task automatic wait_state(input seq_state_t s, input int bound, output int cyc);
    cyc = 0;
    while (state_reg !== s) begin
      @(negedge mclk);
      cyc++;
      if (cyc > bound) begin
        error_cnt++;
        $display("BAD state wait expected %0d seen %0d", s, state_reg);
        final_report();
      end
    end
  endtask : wait_state

  // Result watcher: each fresh valid flag takes the oldest note and compares.
  always @(negedge mclk) begin
    lv_d <= light_valid_reg;
    pv_d <= prox_valid_reg;
    if (light_valid_reg === 1'b1 && lv_d === 1'b0) begin
      if (light_q.size() == 0) begin
        chk("light note", 32'h0000_0000, 32'h0000_0001);
      end else begin
        chk("light counts", light_q.pop_front(), {bb_cnt, ir_cnt});
      end
    end
    if (prox_valid_reg === 1'b1 && pv_d === 1'b0) begin
      if (prox_q.size() == 0) begin
        chk("prox note", 32'h0000_0000, 32'h0000_0001);
      end else begin
        chk("prox result", {16'h0000, prox_q.pop_front()}, {16'h0000, prox_result});
      end
    end
  end

  initial begin
    int c;
    int pulses;
    int wexp;
    light_pair_t held;
    pulses = 0;
    void'($urandom(2343));
    repeat (12) @(negedge mclk);
    rst_b = 1'b1;
    repeat (30) @(negedge mclk);
    chk("state after reset", ST_SLEEP, state_reg);
    chk("pulses after reset", 32'h0000_0000, pulse_cnt);
    for (int i = 0; i < 4; i++) begin
      light_set = light_pair_t'($urandom);
      prox_set = 16'($urandom);
      prox_q.push_back(prox_set);
      light_q.push_back(light_set);
      cfg.light_integration_time = lt[i];
      cfg.prox_integration_time = 8'hFF;
      cfg.wait_duration = wt[i];
      cfg.long_wait_bit = (i == 2);
      cfg.prox_pulse_count = pc[i];
      cfg.emitter_current_select = drive_t'(i);
      cfg.prox_diode_select = diode_t'(i);
      cfg.light_gain_select = gain_t'(3 - i);
      cfg.enable_bits = (i == 1) ? 8'h07 : 8'h0F;
      wait_state(ST_POWER_DELAY, 3, c);
      wait_state(ST_START, STEP + 4, c);
      chk_range("power delay", STEP - 1, STEP + 2, c);
      wait_state(ST_PROX_ACCUM, 3, c);
      chk("drive", i, 32'(emitter_drive_reg));
      chk("diode", i, 32'(diode_route_reg));
      wait_state(ST_PROX_CONV, 4000 * pc[i] + 600, c);
      wait_state((i == 1) ? ST_LIGHT : ST_WAIT, STEP + 4, c);
      pulses += pc[i];
      chk("pulse count", pulses, pulse_cnt);
      chk("pulse on", PULSE_ON_CYCLES, on_len);
      if (pc[i] > 1) begin
        chk("pulse period", PULSE_PERIOD_CYCLES, period_len);
      end
      if (i != 1) begin
        wexp = (256 - wt[i]) * STEP * (i == 2 ? LONG_WAIT_FACTOR : 1);
        wait_state(ST_LIGHT, wexp + 4, c);
        chk_range("wait length", wexp - 1, wexp + 2, c);
      end
      chk("gain", 3 - i, 32'(light_gain_reg));
      chk("integrating", 32'h0000_0001, integ);
      held = {bb_cnt, ir_cnt};
      read_hold = (i == 3);
      cfg.enable_bits = 8'h0E;
      wexp = (256 - lt[i]) * STEP;
      wait_state(ST_SLEEP, wexp + 8, c);
      chk_range("light length", wexp - 1, wexp + 4, c);
      repeat (6) @(negedge mclk);
      if (i == 3) begin
        chk("held counts", held, {bb_cnt, ir_cnt});
        chk("held valid", 32'h0000_0000, light_valid_reg);
        read_hold = 1'b0;
        repeat (6) @(negedge mclk);
      end
      chk("state stays asleep", ST_SLEEP, state_reg);
      chk("integration off", 32'h0000_0000, integ);
      lv_clr = 1'b1;
      pv_clr = 1'b1;
      @(negedge mclk);
      lv_clr = 1'b0;
      pv_clr = 1'b0;
      repeat (3) @(negedge mclk);
    end
    chk("notes left", 32'h0000_0000, light_q.size() + prox_q.size());
    final_report();
  end
endmodule : light_proximity_measurement_sequencer_tb
